// ### bmp_osc.sv
`timescale 1ns/1ps
module bmp_osc
  import bmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  bmp_osc_if.osc port
);

  logic [OSC_W-1:0] ramp_q, ramp_d;
  logic falling_q, falling_d;
  logic side_q, side_d;
  logic top_q, top_d;
  logic bot_q, bot_d;
  logic fall_q, fall_d;

  ////////////////////////////////////////////////////////////////////////////
  // rising ramp drives one side, falling ramp is the deadtime with both low
  always_comb begin
    ramp_d = ramp_q;
    falling_d = falling_q;
    side_d = side_q;
    if (!port.enable) begin
      ramp_d = '0;
      falling_d = 1'b0;
      side_d = 1'b0;
    end else if (!falling_q) begin
      if (ramp_q >= port.period) begin
        falling_d = 1'b1;
        ramp_d = '0;
      end else begin
        ramp_d = ramp_q + 1'b1;
      end
    end else if (ramp_q >= OSC_W'(port.deadtime)) begin
      // t flip-flop alternates the sides, so top and bottom get equal on-times
      falling_d = 1'b0;
      ramp_d = '0;
      side_d = ~side_q;
    end else begin
      ramp_d = ramp_q + 1'b1;
    end
    top_d = port.enable && !falling_d && side_d;
    bot_d = port.enable && !falling_d && !side_d;
    fall_d = bot_q && !bot_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_q <= '0;
      falling_q <= 1'b0;
      side_q <= 1'b0;
      top_q <= 1'b0;
      bot_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      ramp_q <= ramp_d;
      falling_q <= falling_d;
      side_q <= side_d;
      top_q <= top_d;
      bot_q <= bot_d;
      fall_q <= fall_d;
    end
  end

  assign port.top_on = top_q;
  assign port.bottom_on = bot_q;
  assign port.bottom_fall = fall_q;

endmodule : bmp_osc

// ### bmp_osc_if.sv
`timescale 1ns/1ps
interface bmp_osc_if;
  import bmp_pkg::*;
  logic enable;
  logic [OSC_W-1:0] period;
  logic [DT_W-1:0] deadtime;
  logic top_on;
  logic bottom_on;
  logic bottom_fall;

  modport seq (output enable, output period, output deadtime,
               input top_on, input bottom_on, input bottom_fall);
  modport osc (input enable, input period, input deadtime,
               output top_on, output bottom_on, output bottom_fall);
endinterface : bmp_osc_if

// ### bmp_pkg.sv
package bmp_pkg;

  // sequencer modes
  typedef enum logic [2:0] {
    BMP_OFF,
    BMP_STARTUP,
    BMP_PREHEAT,
    BMP_IGNITION,
    BMP_RUN,
    BMP_FAULT
  } bmp_state_t;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TMR_W = 18;
  localparam int LEN_W = 16;
  localparam int OSC_W = 16;
  localparam int DT_W = 8;

  // register byte addresses
  localparam logic [7:0] ADR_PREHEAT = 8'h00;
  localparam logic [7:0] ADR_STARTUP = 8'h04;
  localparam logic [7:0] ADR_OSC = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;

  // field positions
  localparam int OSC_DT_LSB = 16;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_INPUT_LSB = 16;

  // reset values
  localparam logic [LEN_W-1:0] PREHEAT_RST = 16'h0400;
  localparam logic [LEN_W-1:0] STARTUP_RST = 16'h0040;
  localparam logic [OSC_W-1:0] PERIOD_RST = 16'h0190;
  localparam logic [DT_W-1:0] DEAD_RST = 8'h28;

  // fault causes
  localparam int CAUSE_W = 3;
  localparam logic [CAUSE_W-1:0] CAUSE_POS = 3'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_NEG = 3'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_TEMP = 3'h4;

  // byte-lane write merge
  function automatic logic [31:0] bmp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : bmp_merge

endpackage : bmp_pkg

// ### bmp_stage_model.sv
`timescale 1ns/1ps
module bmp_stage_model (
  // gate drives
  input wire logic top_in,
  input wire logic bottom_in,
  // load condition
  input wire logic overcurrent_in,
  input wire logic undercurrent_in,
  // sense comparators
  output logic cs_pos_out,
  output logic cs_neg_out
);
  // sense resistor sits under the bottom switch: no current, no trip
  assign cs_pos_out = bottom_in && overcurrent_in;
  // no load: current stays above the negative level until top turns on
  assign cs_neg_out = undercurrent_in && !top_in;
endmodule : bmp_stage_model

// ### bmp_top.sv
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module bmp_top
  import bmp_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // comparator inputs from the analog front end
  input wire logic SUPPLY_OK_IN,
  input wire logic BUS_VOLTAGE_SENSE_IN,
  input wire logic LAMP_FAULT_INPUT_IN,
  input wire logic CS_POS_TRIP_IN,
  input wire logic CS_NEG_TRIP_IN,
  input wire logic OVER_TEMP_IN,
  // power stage and timing pins
  output logic TOP_SWITCH_DRIVE_OUT,
  output logic BOTTOM_SWITCH_DRIVE_OUT,
  output logic PREHEAT_FREQ_PIN_OE_OUT,
  output logic RUN_PIN_OE_OUT,
  output logic MICROPOWER_OUT,
  output logic FAULT_LATCH_OUT
);

  if (TICK_DIV < 1) begin : g_bad_div
    $error("TICK_DIV must be at least 1");
  end

  localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam int NIN = 6;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  logic [NIN-1:0] meta_q, sync_q;
  logic [NIN-1:0] pins;
  assign pins = {OVER_TEMP_IN, CS_NEG_TRIP_IN, CS_POS_TRIP_IN,
                 LAMP_FAULT_INPUT_IN, BUS_VOLTAGE_SENSE_IN, SUPPLY_OK_IN};

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  logic supply_ok, bus_ok, lamp_fault, cs_pos, cs_neg, over_temp;
  // bus and lamp-fault hysteresis lives in the analog comparators; here only levels
  assign {over_temp, cs_neg, cs_pos, lamp_fault, bus_ok, supply_ok} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // timing tick divider
  logic [DIV_W-1:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 1'b1;
    if (div_q == DIV_W'(TICK_DIV - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file over wishbone
  logic [LEN_W-1:0] ph_len_q, ph_len_d;
  logic [LEN_W-1:0] st_len_q, st_len_d;
  logic [OSC_W-1:0] period_q, period_d;
  logic [DT_W-1:0] dead_q, dead_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] status_w;
  logic [31:0] wv;
  bmp_state_t state_q, state_d;
  logic fault_q, fault_d;
  logic [CAUSE_W-1:0] cause_q, cause_d;

  always_comb begin
    status_w = '0;
    status_w[ST_STATE_LSB +: 3] = state_q;
    status_w[ST_FAULT_BIT] = fault_q;
    status_w[ST_CAUSE_LSB +: CAUSE_W] = cause_q;
    status_w[ST_INPUT_LSB +: NIN] = sync_q;
  end

  always_comb begin
    ph_len_d = ph_len_q;
    st_len_d = st_len_q;
    period_d = period_q;
    dead_d = dead_q;
    rdat_d = rdat_q;
    wv = '0;
    ack_d = WB_CYC_IN && WB_STB_IN && !ack_q;
    if (ack_d) begin
      rdat_d = '0;
      unique case (WB_ADR_IN)
        ADR_PREHEAT: begin
          wv = bmp_merge({16'h0000, ph_len_q}, WB_DAT_IN, WB_SEL_IN);
          rdat_d = {16'h0000, ph_len_q};
          if (WB_WE_IN) begin
            ph_len_d = wv[LEN_W-1:0];
          end
        end
        ADR_STARTUP: begin
          wv = bmp_merge({16'h0000, st_len_q}, WB_DAT_IN, WB_SEL_IN);
          rdat_d = {16'h0000, st_len_q};
          if (WB_WE_IN) begin
            st_len_d = wv[LEN_W-1:0];
          end
        end
        ADR_OSC: begin
          wv = bmp_merge({8'h00, dead_q, period_q}, WB_DAT_IN, WB_SEL_IN);
          rdat_d = {8'h00, dead_q, period_q};
          if (WB_WE_IN) begin
            period_d = wv[OSC_W-1:0];
            dead_d = wv[OSC_DT_LSB +: DT_W];
          end
        end
        ADR_STATUS: begin
          rdat_d = status_w;
        end
        default: begin
          rdat_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ph_len_q <= PREHEAT_RST;
      st_len_q <= STARTUP_RST;
      period_q <= PERIOD_RST;
      dead_q <= DEAD_RST;
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ph_len_q <= ph_len_d;
      st_len_q <= st_len_d;
      period_q <= period_d;
      dead_q <= dead_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and gate drive
  bmp_osc_if osc_if ();

  bmp_osc u_osc (
    .clk(CLOCK_IN),
    .rst_n(rst_n),
    .port(osc_if.osc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer and protection
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] ph_end, ign_end;
  logic start_ok, running, pos_fault, neg_fault;
  logic ph_sw_q, ph_sw_d;
  logic run_sw_q, run_sw_d;
  logic mp_q, mp_d;

  assign ph_end = TMR_W'(ph_len_q);
  assign ign_end = TMR_W'(ph_len_q) + TMR_W'(ph_len_q >> 2);
  assign start_ok = supply_ok && bus_ok && !lamp_fault;
  assign running = (state_q == BMP_STARTUP) || (state_q == BMP_PREHEAT) ||
                   (state_q == BMP_IGNITION) || (state_q == BMP_RUN);
  // current at the low-side resistor judged while each bottom pulse is on, in ignition and run only
  assign pos_fault = cs_pos && osc_if.bottom_on &&
                     ((state_q == BMP_IGNITION) || (state_q == BMP_RUN));
  assign neg_fault = cs_neg && osc_if.bottom_fall && (state_q == BMP_RUN);

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    fault_d = fault_q;
    cause_d = cause_q;
    if (!supply_ok) begin
      state_d = BMP_OFF;
      fault_d = 1'b0;
      cause_d = '0;
    end else if (lamp_fault) begin
      state_d = BMP_OFF;
      fault_d = 1'b0;
      cause_d = '0;
    end else if (fault_q) begin
      state_d = BMP_FAULT;
    end else if (running && (pos_fault || neg_fault || over_temp)) begin
      state_d = BMP_FAULT;
      fault_d = 1'b1;
      cause_d = {over_temp, neg_fault, pos_fault};
    end else if (running && !bus_ok) begin
      state_d = BMP_OFF;
    end else begin
      unique case (state_q)
        BMP_OFF, BMP_FAULT: begin
          tmr_d = '0;
          if (start_ok) begin
            state_d = BMP_STARTUP;
          end
        end
        BMP_STARTUP: begin
          if (tick_q) begin
            tmr_d = tmr_q + 1'b1;
          end
          if (tmr_q >= TMR_W'(st_len_q)) begin
            state_d = BMP_PREHEAT;
            tmr_d = '0;
          end
        end
        BMP_PREHEAT: begin
          if (tick_q) begin
            tmr_d = tmr_q + 1'b1;
          end
          if (tmr_q >= ph_end) begin
            state_d = BMP_IGNITION;
          end
        end
        BMP_IGNITION: begin
          if (tick_q) begin
            tmr_d = tmr_q + 1'b1;
          end
          if (tmr_q >= ign_end) begin
            state_d = BMP_RUN;
          end
        end
        BMP_RUN: begin
          state_d = BMP_RUN;
        end
      endcase
    end
    // timer never carries into a new run of the sequence
    if (state_d == BMP_OFF || state_d == BMP_FAULT) begin
      tmr_d = '0;
    end
    ph_sw_d = !(state_d == BMP_IGNITION || state_d == BMP_RUN);
    run_sw_d = (state_d == BMP_RUN);
    mp_d = (state_d == BMP_OFF || state_d == BMP_FAULT);
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BMP_OFF;
      tmr_q <= '0;
      fault_q <= 1'b0;
      cause_q <= '0;
      ph_sw_q <= 1'b1;
      run_sw_q <= 1'b0;
      mp_q <= 1'b1;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      fault_q <= fault_d;
      cause_q <= cause_d;
      ph_sw_q <= ph_sw_d;
      run_sw_q <= run_sw_d;
      mp_q <= mp_d;
    end
  end

  // oscillator only runs in the four operating modes
  assign osc_if.enable = running && !mp_q;
  assign osc_if.period = period_q;
  assign osc_if.deadtime = dead_q;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign WB_DAT_OUT = rdat_q;
  assign WB_ACK_OUT = ack_q;
  assign TOP_SWITCH_DRIVE_OUT = osc_if.top_on;
  assign BOTTOM_SWITCH_DRIVE_OUT = osc_if.bottom_on;
  assign PREHEAT_FREQ_PIN_OE_OUT = ph_sw_q;
  assign RUN_PIN_OE_OUT = run_sw_q;
  assign MICROPOWER_OUT = mp_q;
  assign FAULT_LATCH_OUT = fault_q;

endmodule : bmp_top

// ### bmp_top_assertions.sv
`timescale 1ns/1ps
module bmp_top_assertions (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // comparators
  input wire logic SUPPLY_OK_IN,
  input wire logic BUS_VOLTAGE_SENSE_IN,
  input wire logic LAMP_FAULT_INPUT_IN,
  input wire logic CS_POS_TRIP_IN,
  // power stage
  input wire logic TOP_SWITCH_DRIVE_OUT,
  input wire logic BOTTOM_SWITCH_DRIVE_OUT,
  input wire logic PREHEAT_FREQ_PIN_OE_OUT,
  input wire logic RUN_PIN_OE_OUT,
  input wire logic MICROPOWER_OUT,
  input wire logic FAULT_LATCH_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  logic start_ok;
  assign start_ok = SUPPLY_OK_IN && BUS_VOLTAGE_SENSE_IN && !LAMP_FAULT_INPUT_IN;
  ////////////////////////////////////////
  gates_apart_a: assert property (!(TOP_SWITCH_DRIVE_OUT && BOTTOM_SWITCH_DRIVE_OUT))
    else $error("gates overlap");
  quiet_gates_a: assert property (MICROPOWER_OUT[*4] |->
    !TOP_SWITCH_DRIVE_OUT && !BOTTOM_SWITCH_DRIVE_OUT) else $error("gates in micropower");
  lamp_off_a: assert property (LAMP_FAULT_INPUT_IN[*6] |->
    MICROPOWER_OUT && !FAULT_LATCH_OUT) else $error("lamp input ignored");
  supply_clear_a: assert property ((!SUPPLY_OK_IN)[*6] |->
    MICROPOWER_OUT && !FAULT_LATCH_OUT) else $error("supply low ignored");
  start_gate_a: assert property ($fell(MICROPOWER_OUT) |->
    $past(start_ok, 3) || $past(start_ok, 4) || $past(start_ok, 5)) else $error("bad start");
  fault_hold_a: assert property ((SUPPLY_OK_IN && !LAMP_FAULT_INPUT_IN)[*5] ##0
    FAULT_LATCH_OUT |=> FAULT_LATCH_OUT) else $error("latch lost");
  pos_trip_a: assert property ($rose(CS_POS_TRIP_IN) && !PREHEAT_FREQ_PIN_OE_OUT
    && !MICROPOWER_OUT |-> ##[1:40] FAULT_LATCH_OUT) else $error("trip missed");
  ramp_order_a: assert property ($fell(PREHEAT_FREQ_PIN_OE_OUT) |->
    !RUN_PIN_OE_OUT && !MICROPOWER_OUT) else $error("bad ramp entry");
endmodule : bmp_top_assertions
bind bmp_top bmp_top_assertions u_chk (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
  .SUPPLY_OK_IN(SUPPLY_OK_IN), .BUS_VOLTAGE_SENSE_IN(BUS_VOLTAGE_SENSE_IN),
  .LAMP_FAULT_INPUT_IN(LAMP_FAULT_INPUT_IN), .CS_POS_TRIP_IN(CS_POS_TRIP_IN),
  .TOP_SWITCH_DRIVE_OUT(TOP_SWITCH_DRIVE_OUT), .BOTTOM_SWITCH_DRIVE_OUT(BOTTOM_SWITCH_DRIVE_OUT),
  .PREHEAT_FREQ_PIN_OE_OUT(PREHEAT_FREQ_PIN_OE_OUT), .RUN_PIN_OE_OUT(RUN_PIN_OE_OUT),
  .MICROPOWER_OUT(MICROPOWER_OUT), .FAULT_LATCH_OUT(FAULT_LATCH_OUT));

// ### bmp_top_bench.sv
`timescale 1ns/1ps
module bmp_top_bench;
  import bmp_pkg::*;
  localparam int PH = 160;
  localparam int SU = 8;
  localparam int ON_CYC = 4;
  localparam int GAP_CYC = 3;
  logic clk, rst_b, cyc, stb, we, ack, sup, bus, lamp, csp, csn, temp, heavy, uc;
  logic top, bot, ph_oe, run_oe, micro, latch;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [5:0] p;
  logic [31:0] wd, rdat;
  logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
  int err_total, compares, n;
  assign p = {top, bot, latch, run_oe, ph_oe, micro};
  bmp_top #(.TICK_DIV(1)) DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SUPPLY_OK_IN(sup), .BUS_VOLTAGE_SENSE_IN(bus),
    .LAMP_FAULT_INPUT_IN(lamp), .CS_POS_TRIP_IN(csp), .CS_NEG_TRIP_IN(csn),
    .OVER_TEMP_IN(temp), .TOP_SWITCH_DRIVE_OUT(top), .BOTTOM_SWITCH_DRIVE_OUT(bot),
    .PREHEAT_FREQ_PIN_OE_OUT(ph_oe), .RUN_PIN_OE_OUT(run_oe), .MICROPOWER_OUT(micro),
    .FAULT_LATCH_OUT(latch));
  bmp_stage_model u_stage (.top_in(top), .bottom_in(bot), .overcurrent_in(heavy),
    .undercurrent_in(uc), .cs_pos_out(csp), .cs_neg_out(csn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  // a hang counts as a mismatch and ends the run
  task automatic lim(input logic ok);
    if (!ok) begin
      err_total++;
      print_verdict();
    end
  endtask : lim
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] m, input logic [31:0] exp);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    lim(ack === 1'b1);
    if (!w) chk(rdat & m, exp);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wt(input int k, input logic v, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (p[k] !== v && c < 400);
    lim(p[k] === v);
  endtask : wt
  task automatic drv(input logic [2:0] v);
    @(posedge clk);
    {sup, bus, lamp} <= v;
  endtask : drv
  function automatic logic [31:0] st(input logic [2:0] c, input bmp_state_t s);
    return (32'(c) << ST_CAUSE_LSB) | (32'(c != 3'h0) << ST_FAULT_BIT) | 32'(s);
  endfunction : st
  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, adr, sel, wd} = '0;
    {sup, bus, lamp, temp, heavy, uc} = 6'b111000;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    chk(32'({top, bot, ph_oe, run_oe, micro, latch}), 32'h0000_000A);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wb(0, ADR_PREHEAT, '0, 4'hf, '1, 32'(PREHEAT_RST));
    wb(0, ADR_OSC, '0, 4'hf, '1, {8'h00, DEAD_RST, PERIOD_RST});
    wb(1, 8'h10, '1, 4'hf, '0, '0);
    wb(0, 8'h10, '0, 4'hf, '1, 32'h0000_0000);
    wb(1, ADR_PREHEAT, 32'(PH), 4'hf, '0, '0);
    wb(1, ADR_STARTUP, 32'(SU), 4'hf, '0, '0);
    wb(1, ADR_OSC, 32'h0002_0004, 4'hf, '0, '0);
    wb(1, ADR_OSC, 32'h0003_FFFF, 4'h4, '0, '0);
    wb(0, ADR_OSC, '0, 4'hf, '1, 32'h0003_0004);
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_001F, st(3'h0, BMP_OFF));
    for (int i = 0; i < 3; i++) begin
      drv(bad[i]);
      repeat (30) @(posedge clk);
      chk(32'(micro), 32'h0000_0001);
    end
    // overcurrent from the start: only ignition or run may trip on it
    heavy <= 1'b1;
    drv(3'b110);
    wt(0, 1'b0, n);
    wt(1, 1'b0, n);
    chk(32'(n >= PH && n <= PH + SU + 8), 32'h0000_0001);
    chk(32'(latch), 32'h0000_0000);
    wt(3, 1'b1, n);
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_071F, st(CAUSE_POS, BMP_FAULT));
    chk(32'({run_oe, micro}), 32'h0000_0001);
    heavy <= 1'b0;
    drv(3'b111);
    wt(3, 1'b0, n);
    uc <= 1'b1;
    drv(3'b110);
    wt(1, 1'b0, n);
    wt(2, 1'b1, n);
    chk(32'(n >= PH / 4 && n <= PH / 4 + 2), 32'h0000_0001);
    wt(3, 1'b1, n);
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_071F, st(CAUSE_NEG, BMP_FAULT));
    drv(3'b010);
    wt(3, 1'b0, n);
    uc <= 1'b0;
    drv(3'b110);
    wt(2, 1'b1, n);
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_001F, st(3'h0, BMP_RUN));
    // start from a real top rising edge so every pulse is measured whole
    wt(5, 1'b0, n);
    wt(5, 1'b1, n);
    wt(4, 1'b1, n);
    chk(32'(n), 32'(ON_CYC + GAP_CYC + 2));
    wt(4, 1'b0, n);
    chk(32'(n), 32'(ON_CYC + 1));
    wt(5, 1'b1, n);
    chk(32'(n), 32'(GAP_CYC + 1));
    drv(3'b100);
    wt(0, 1'b1, n);
    chk(32'({ph_oe, run_oe, latch}), 32'h0000_0004);
    drv(3'b110);
    wt(0, 1'b0, n);
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_0007, 32'(BMP_STARTUP));
    wt(2, 1'b1, n);
    temp <= 1'b1;
    wt(3, 1'b1, n);
    temp <= 1'b0;
    wb(0, ADR_STATUS, '0, 4'hf, 32'h0000_071F, st(CAUSE_TEMP, BMP_FAULT));
    drv(3'b111);
    wt(3, 1'b0, n);
    drv(3'b110);
    wt(0, 1'b0, n);
    print_verdict();
  end
endmodule : bmp_top_bench
